// ===== src/timer_wake_pkg.sv
// Shared constants, field positions and carrier types of the timer and wake block.
// Assumes a single 50 MHz system clock and an instruction decoder that pulses writes.
`default_nettype none
package timer_wake_pkg;
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned SUB_OSC_HZ      = 32768;
  localparam int unsigned SUB_DIV_COUNT   = CLK_HZ / SUB_OSC_HZ;
  localparam int unsigned DIV64           = 64;
  localparam int unsigned DIV4            = 4;
  localparam int unsigned DIV1024         = 1024;
  localparam int unsigned VECTOR_FIRST    = 12'h004;
  localparam int unsigned VECTOR_LAST     = 12'h020;
  localparam logic [3:0]  MODE_RESET      = 4'h0;
  localparam logic [7:0]  COUNT_RESET     = 8'h00;
  localparam logic [7:0]  COUNT_WRAP      = 8'hff;
  // Mode bit positions
  localparam int unsigned MODE_SEL0       = 0;
  localparam int unsigned MODE_SEL1       = 1;
  localparam int unsigned MODE_OUT        = 2;
  localparam int unsigned MODE_RUN        = 3;
  // Event flag positions
  localparam int unsigned EV_DIV0         = 0;
  localparam int unsigned EV_TMR0         = 1;
  localparam int unsigned EV_PORT         = 2;
  localparam int unsigned EV_DIV1         = 4;
  localparam int unsigned EV_TMR1         = 7;
  localparam logic [7:0]  EV_USED         = 8'h97;

  typedef struct packed {
    logic       mode0_we;
    logic       mode1_we;
    logic       wake_we;
    logic       low_we;
    logic       high_we;
    logic       ien_we;
    logic       hen_we;
    logic       pen_we;
    logic       evclr_we;
    logic [7:0] data;
  } cpu_write_type;

  typedef struct packed {
    logic en_int;
    logic global_interrupt_disable_instr;
    logic int_ack;
    logic ret;
    logic hold;
    logic stop;
    logic slow_mode;
  } cpu_ctrl_type;
endpackage
`default_nettype wire

// ===== src/rate_divider.sv
// Enable pulse generator dividing the system clock by a count.
// Assumes the system clock and reset.
`default_nettype none
module rate_divider
  import timer_wake_pkg::*;
#(
  parameter int unsigned DIV = 64
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pulse
  output logic      tick
);
  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  logic         tick_d;

  always_comb
  begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + 1'b1;
    if (cnt_q == W'(DIV - 1))
    begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule // rate_divider
`default_nettype wire

// ===== src/pin_sync.sv
// Two-stage synchroniser for a bus of asynchronous pins.
// Assumes pins are unrelated to clk.
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 4
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Pins
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  assign sync = sync_q;
endmodule // pin_sync
`default_nettype wire

// ===== src/reload_timer_and_wake_control.sv
// Second auto-reload timer, timer modes, interrupt gating and stop-mode wake.
// Assumes the instruction decoder pulses writes and control strobes for one cycle.
`default_nettype none
module reload_timer_and_wake_control
  import timer_wake_pkg::*;
#(
  parameter int unsigned SUB_DIV = SUB_DIV_COUNT
)(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Instruction side
  input  wire cpu_write_type wr,
  input  wire cpu_ctrl_type  ctrl,
  // External events
  input  wire logic          div0_event,
  input  wire logic          div1_event,
  input  wire logic          tmr0_event,
  input  wire logic          port_change,
  input  wire logic          tone_wave,
  // Pins
  input  wire logic [3:0]    wake_input_port,
  output logic               multi_function_output,
  // Status to core
  output logic               irq_req,
  output logic [11:0]        irq_vector,
  output logic               hold_active,
  output logic               stop_active,
  output logic               main_osc_enable,
  output logic [7:0]         event_flags,
  output logic               first_timer_run,
  output logic               first_timer_slow
);
  logic       tick64;
  logic       tick_sub;
  logic [3:0] port_s;

  rate_divider #(.DIV(DIV64)) u_div64
  (
    .clk  (clk),
    .rst  (rst),
    .tick (tick64)
  );

  rate_divider #(.DIV(SUB_DIV)) u_divsub
  (
    .clk  (clk),
    .rst  (rst),
    .tick (tick_sub)
  );

  pin_sync #(.W(4)) u_sync
  (
    .clk  (clk),
    .rst  (rst),
    .pin  (wake_input_port),
    .sync (port_s)
  );

  logic [3:0]  mode0_q, mode0_d, mode1_q, mode1_d, wake_q, wake_d, pen_q, pen_d;
  logic [7:0]  buf_q, buf_d, cnt_q, cnt_d, ev_q, ev_d, ien_q, ien_d, hen_q, hen_d;
  logic        sq_q, sq_d, mfo_q, mfo_d, gie_q, gie_d, irq_q, irq_d;
  logic        hold_q, hold_d, stop_q, stop_d, rehold_q, rehold_d, mosc_q, mosc_d;
  logic [11:0] vec_q, vec_d;
  logic [3:0]  port_prev_q;
  logic        tmr_tick, underflow;
  logic [7:0]  pending;
  logic [3:0]  fall;

  function automatic logic [11:0] vec_of(input logic [7:0] p);
    logic [11:0] v;
    v = 12'(VECTOR_LAST);
    if (p[EV_DIV0])
      v = 12'(VECTOR_FIRST);
    else if (p[EV_TMR0])
      v = 12'h008;
    else if (p[EV_PORT])
      v = 12'h00c;
    else if (p[EV_DIV1])
      v = 12'h010;
    return v;
  endfunction

  // Event flag bit served by a vector
  function automatic logic [7:0] src_of(input logic [11:0] v);
    logic [7:0] m;
    m = 8'h00;
    unique case (v)
      12'(VECTOR_FIRST): m[EV_DIV0] = 1'b1;
      12'h008:           m[EV_TMR0] = 1'b1;
      12'h00c:           m[EV_PORT] = 1'b1;
      12'h010:           m[EV_DIV1] = 1'b1;
      12'(VECTOR_LAST):  m[EV_TMR1] = 1'b1;
      default:           m = 8'h00;
    endcase
    return m;
  endfunction

  always_comb
  begin
    if (mode1_q[MODE_SEL1])
      tmr_tick = tick_sub;
    else if (mode1_q[MODE_SEL0])
      tmr_tick = tick64;
    else
      tmr_tick = 1'b1;
  end

  assign underflow = mode1_q[MODE_RUN] && tmr_tick && !stop_q && !wr.mode1_we
                     && (cnt_q == COUNT_RESET);
  assign fall      = port_prev_q & ~port_s;
  assign pending   = ev_q & ien_q & EV_USED;

  always_comb
  begin
    mode0_d  = mode0_q;
    mode1_d  = mode1_q;
    wake_d   = wake_q;
    pen_d    = pen_q;
    buf_d    = buf_q;
    cnt_d    = cnt_q;
    ev_d     = ev_q;
    ien_d    = ien_q;
    hen_d    = hen_q;
    sq_d     = sq_q;
    gie_d    = gie_q;
    hold_d   = hold_q;
    stop_d   = stop_q;
    rehold_d = rehold_q;
    mosc_d   = mosc_q;
    if (wr.mode0_we)
      mode0_d = wr.data[3:0];
    if (wr.wake_we)
      wake_d = wr.data[3:0];
    if (wr.pen_we)
      pen_d = wr.data[3:0];
    if (wr.low_we)
      buf_d[3:0] = wr.data[3:0];
    if (wr.high_we)
      buf_d[7:4] = wr.data[3:0];
    if (wr.hen_we)
      hen_d = wr.data & EV_USED;
    if (wr.ien_we)
    begin
      ien_d = wr.data & EV_USED;
      gie_d = 1'b1;
    end
    if (ctrl.en_int)
      gie_d = 1'b1;
    if (ctrl.global_interrupt_disable_instr)
      gie_d = 1'b0;
    if (wr.evclr_we)
      ev_d = ev_d & ~wr.data;
    if (ctrl.int_ack)
    begin
      ev_d  = ev_d & ~src_of(vec_q);
      gie_d = 1'b0;
    end
    if (wr.mode1_we)
    begin
      mode1_d = wr.data[3:0];
      if (wr.data[MODE_RUN])
      begin
        cnt_d          = buf_q;
        ev_d[EV_TMR1]  = 1'b0;
      end
    end
    else if (mode1_q[MODE_RUN] && tmr_tick && !stop_q)
    begin
      if (underflow)
        cnt_d = buf_q;
      else
        cnt_d = cnt_q - 8'h01;
    end
    if (underflow)
      sq_d = ~sq_q;
    // Hardware sets win over clears
    if (div0_event)
      ev_d[EV_DIV0] = 1'b1;
    if (tmr0_event)
      ev_d[EV_TMR0] = 1'b1;
    if (div1_event)
      ev_d[EV_DIV1] = 1'b1;
    if (port_change && |pen_q)
      ev_d[EV_PORT] = 1'b1;
    if (underflow)
      ev_d[EV_TMR1] = 1'b1;
    if (ctrl.hold)
      hold_d = 1'b1;
    if (|(ev_d & hen_q))
      hold_d = 1'b0;
    if (hold_q && |pending && gie_q)
    begin
      hold_d   = 1'b0;
      rehold_d = 1'b1;
    end
    if (ctrl.ret && rehold_q)
    begin
      hold_d   = 1'b1;
      rehold_d = 1'b0;
    end
    if (ctrl.stop)
    begin
      mosc_d = 1'b0;
      stop_d = !ctrl.slow_mode;
    end
    if (stop_q && |(fall & wake_q))
    begin
      stop_d = 1'b0;
      mosc_d = 1'b1;
    end
  end

  always_comb
  begin
    mfo_d = mode1_q[MODE_OUT] ? sq_q : tone_wave;
    if (stop_q)
      mfo_d = 1'b1;
    irq_d = gie_q && |pending && !ctrl.int_ack;
    vec_d = vec_of(pending);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode0_q     <= MODE_RESET;
      mode1_q     <= MODE_RESET;
      wake_q      <= MODE_RESET;
      pen_q       <= MODE_RESET;
      buf_q       <= COUNT_RESET;
      cnt_q       <= COUNT_RESET;
      ev_q        <= COUNT_RESET;
      ien_q       <= COUNT_RESET;
      hen_q       <= COUNT_RESET;
      sq_q        <= 1'b0;
      mfo_q       <= 1'b0;
      gie_q       <= 1'b1;
      irq_q       <= 1'b0;
      hold_q      <= 1'b0;
      stop_q      <= 1'b0;
      rehold_q    <= 1'b0;
      mosc_q      <= 1'b1;
      vec_q       <= 12'(VECTOR_LAST);
      port_prev_q <= 4'hf;
    end
    else
    begin
      mode0_q     <= mode0_d;
      mode1_q     <= mode1_d;
      wake_q      <= wake_d;
      pen_q       <= pen_d;
      buf_q       <= buf_d;
      cnt_q       <= cnt_d;
      ev_q        <= ev_d;
      ien_q       <= ien_d;
      hen_q       <= hen_d;
      sq_q        <= sq_d;
      mfo_q       <= mfo_d;
      gie_q       <= gie_d;
      irq_q       <= irq_d;
      hold_q      <= hold_d;
      stop_q      <= stop_d;
      rehold_q    <= rehold_d;
      mosc_q      <= mosc_d;
      vec_q       <= vec_d;
      port_prev_q <= port_s;
    end
  end

  assign multi_function_output = mfo_q;
  assign irq_req               = irq_q;
  assign irq_vector            = vec_q;
  assign hold_active           = hold_q;
  assign stop_active           = stop_q;
  assign main_osc_enable       = mosc_q;
  assign event_flags           = ev_q;
  assign first_timer_run       = mode0_q[MODE_RUN];
  assign first_timer_slow      = mode0_q[MODE_SEL0];

  run_clear_a: assert property (@(posedge clk) disable iff (rst)
    (wr.mode1_we && wr.data[MODE_RUN] && !underflow) |=> !ev_q[EV_TMR1])
    else $error("start did not clear flag");
  wrap_reload_a: assert property (@(posedge clk) disable iff (rst)
    (underflow && !wr.mode1_we) |=> (cnt_q == $past(buf_q) && ev_q[EV_TMR1]))
    else $error("underflow reload wrong");
  halt_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!mode1_q[MODE_RUN] && !wr.mode1_we) |=> $stable(cnt_q))
    else $error("halted counter moved");
  stop_high_a: assert property (@(posedge clk) disable iff (rst)
    stop_q |=> multi_function_output)
    else $error("output not high in stop");
  out_route_a: assert property (@(posedge clk) disable iff (rst)
    (mode1_q[MODE_OUT] && !stop_q) |=> multi_function_output == $past(sq_q))
    else $error("output routing wrong");
  wake_edge_a: assert property (@(posedge clk) disable iff (rst)
    (stop_q && |(fall & wake_q) && !ctrl.stop) |=> !stop_q)
    else $error("no wake on edge");
  irq_gate_a: assert property (@(posedge clk) disable iff (rst)
    irq_req |-> $past(|pending && gie_q))
    else $error("request without cause");
  sq_toggle_a: assert property (@(posedge clk) disable iff (rst)
    underflow |=> sq_q != $past(sq_q))
    else $error("square did not toggle");
  preset_keep_a: assert property (@(posedge clk) disable iff (rst)
    (wr.low_we && !wr.mode1_we && !mode1_q[MODE_RUN]) |=> $stable(cnt_q))
    else $error("preset disturbed counter");
endmodule // reload_timer_and_wake_control
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the reload timer and wake control block.
// Assumes a 50 MHz clock and a short sub-oscillator divider of 4.
`default_nettype none
module testbench
  import timer_wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int       SUBD = 4;
  localparam logic [8:0] M0 = 9'h100, M1 = 9'h080, WK = 9'h040, LO = 9'h020;
  localparam logic [8:0] HI = 9'h010, IE = 9'h008, HE = 9'h004, EC = 9'h001;
  localparam logic [6:0] EN = 7'h40, DIS = 7'h20, ACK = 7'h10, HLD = 7'h04, STP = 7'h02;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  cpu_write_type wr = '0;
  cpu_ctrl_type  ctrl = '0;
  logic          div0_event = 1'b0;
  logic          tone_wave = 1'b0;
  logic [3:0]    wake_input_port = 4'hf;
  logic          multi_function_output, irq_req, hold_active, stop_active;
  logic          main_osc_enable, first_timer_run, first_timer_slow;
  logic [11:0]   irq_vector;
  logic [7:0]    event_flags;
  int            failures = 0;
  int            samples_checked = 0;
  int            cycles = 0;
  int            n, i;
  int            dv[4] = '{1, 64, SUBD, SUBD};
  logic          v;

  reload_timer_and_wake_control #(.SUB_DIV(SUBD)) DUT (
    .clk(clk), .rst(rst), .wr(wr), .ctrl(ctrl),
    .div0_event(div0_event), .div1_event(1'b0), .tmr0_event(1'b0),
    .port_change(1'b0), .tone_wave(tone_wave),
    .wake_input_port(wake_input_port),
    .multi_function_output(multi_function_output),
    .irq_req(irq_req), .irq_vector(irq_vector), .hold_active(hold_active),
    .stop_active(stop_active), .main_osc_enable(main_osc_enable),
    .event_flags(event_flags), .first_timer_run(first_timer_run),
    .first_timer_slow(first_timer_slow)
  );

  always #10 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k)
    begin
      @(posedge clk);
      #1;
    end
  endtask

  // One-cycle register write
  task automatic put(input logic [8:0] we, input logic [7:0] d);
    @(posedge clk);
    wr <= cpu_write_type'({we, d});
    @(posedge clk);
    wr <= '0;
    #1;
  endtask

  // One-cycle control strobe; slow mode level kept
  task automatic pulse(input logic [6:0] c);
    @(posedge clk);
    ctrl <= cpu_ctrl_type'(c | {6'h00, ctrl.slow_mode});
    @(posedge clk);
    ctrl <= cpu_ctrl_type'({6'h00, ctrl.slow_mode});
    #1;
  endtask

  // Cycles until the output pin changes
  task automatic tog(output int k);
    logic w;
    w = multi_function_output;
    k = 0;
    while (multi_function_output === w && k < 3000)
    begin
      cyc(1);
      k++;
    end
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk({irq_req, stop_active, hold_active, multi_function_output, main_osc_enable},
        5'b00001);
    chk(event_flags, 8'h00);
    chk(irq_vector, 12'h020);
    put(M0, 8'h09);
    chk({first_timer_run, first_timer_slow}, 2'b11);
    put(M0, 8'h06);
    chk({first_timer_run, first_timer_slow}, 2'b00);
    put(LO, 8'h02);
    put(HI, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      put(M1, 8'h0c | 8'(i));
      chk(event_flags[7], 1'b0);
      tog(n);
      tog(n);
      chk(n, 3 * dv[i]);
      chk(event_flags[7], 1'b1);
    end
    put(M1, 8'h0c);
    tog(n);
    put(HI, 8'h01);
    put(LO, 8'h00);
    tog(n);
    chk(n <= 3, 1'b1);
    tog(n);
    chk(n, 17);
    put(EC, 8'hff);
    @(posedge clk);
    div0_event <= 1'b1;
    @(posedge clk);
    div0_event <= 1'b0;
    put(IE, 8'h80);
    for (n = 0; n < 50 && irq_req !== 1'b1; n++) cyc(1);
    chk(irq_req, 1'b1);
    chk(irq_vector, 12'h020);
    pulse(ACK);
    chk(event_flags[7], 1'b0);
    chk(event_flags[0], 1'b1);
    for (n = 0; n < 50 && event_flags[7] !== 1'b1; n++) cyc(1);
    cyc(3);
    chk(irq_req, 1'b0);
    pulse(EN);
    cyc(3);
    chk(irq_req, 1'b1);
    pulse(DIS);
    cyc(3);
    chk(irq_req, 1'b0);
    put(IE, 8'h00);
    put(HE, 8'h80);
    put(M1, 8'h04);
    put(EC, 8'h80);
    v = multi_function_output;
    pulse(HLD);
    cyc(20);
    chk(multi_function_output, v);
    chk(hold_active, 1'b1);
    put(M1, 8'h0c);
    for (n = 0; n < 40 && hold_active !== 1'b0; n++) cyc(1);
    chk(hold_active, 1'b0);
    put(M1, 8'h08);
    @(posedge clk);
    tone_wave <= 1'b1;
    cyc(3);
    chk(multi_function_output, 1'b1);
    @(posedge clk);
    tone_wave <= 1'b0;
    cyc(3);
    chk(multi_function_output, 1'b0);
    put(M1, 8'h0c);
    put(WK, 8'h01);
    pulse(STP);
    cyc(10);
    chk({stop_active, multi_function_output}, 2'b11);
    @(posedge clk);
    wake_input_port <= 4'hd;
    cyc(8);
    chk(stop_active, 1'b1);
    @(posedge clk);
    wake_input_port <= 4'hc;
    cyc(8);
    chk(stop_active, 1'b0);
    pulse(STP | 7'h01);
    cyc(3);
    chk({main_osc_enable, stop_active}, 2'b00);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
